// ==== rtl/async_line_with_modem_control.sv ====
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module async_line_with_modem_control #(
   parameter int data_w = 8
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                clk_en,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic      [1:0]          hresp,
   input  wire line_pkg::straps_t   straps,
   input  wire logic                rx_tick16,
   input  wire logic                tx_tick,
   input  wire logic                serial_in,
   input  wire line_pkg::modem_in_t modem_in,
   output logic                     serial_out,
   output logic                     rts_out,
   output logic                     dtr_out,
   output logic                     reverse_channel_out,
   output logic                     rx_irq,
   output logic                     tx_irq
);
   // Bus address phase capture.
   logic        wr_pend_ff;
   logic [3:0]  addr_ff;
   // Only the first four words answer; aliases above them read zero.
   wire         in_map  = haddr[31:4] == '0;
   wire         addr_ok = hsel && hready && in_map &&
                          htrans == line_pkg::htrans_nonseq;
   wire         wr_now  = wr_pend_ff && clk_en;
   wire         rd_now  = addr_ok && !hwrite && clk_en;

   // Control bits written by software.
   logic dtr_ff, rts_ff, rev_ff, ds_ie_ff, rx_ie_ff, tx_ie_ff;
   logic brk_ff, loopback_select_ff;

   // Receive side state.
   line_pkg::ser_st_t rx_st_ff;
   logic [3:0]  rx_os_ff;
   logic [2:0]  rx_bit_ff;
   logic [7:0]  rx_sh_ff, rx_hold_ff;
   logic        rx_char_complete_ff, over_ff, rx_stop_bit_flag_ff, par_ff;
   logic        rx_par_ff;
   // Transmit side state.
   line_pkg::ser_st_t tx_st_ff;
   logic [7:0]  tx_hold_ff, tx_sh_ff;
   logic        hold_full_ff, tx_buffer_empty_ff;
   logic [2:0]  tx_bit_ff;
   logic [1:0]  tx_half_ff;
   logic        tx_par_ff, line_ff;
   // Modem edge detection.
   line_pkg::modem_in_t mdm_ff;
   logic        ds_int_ff;

   // Shared format from the straps, one set for both directions.
   wire [2:0] last_bit = {1'b1, straps.len_sel};
   wire       par_en   = !straps.parity_off_strap;
   wire       even     = !straps.even_parity_strap;

   // Loopback feeds rx from tx; each tx_tick then stands for a whole bit.
   wire rx_line = loopback_select_ff ? line_ff : serial_in;
   wire rx_tk   = clk_en && (loopback_select_ff ? tx_tick : rx_tick16);
   wire rx_mid  = rx_tk && (loopback_select_ff ||
                            rx_os_ff == line_pkg::os_mid);
   wire rx_end  = rx_tk && (loopback_select_ff ||
                            rx_os_ff == line_pkg::os_last);
   wire tx_tk   = clk_en && tx_tick;
   wire stop_mid = rx_mid && rx_st_ff == line_pkg::st_stop;

   // Receive state machine, sampling each bit at its centre.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_ff <= line_pkg::st_idle;
         rx_os_ff <= '0;
         rx_bit_ff <= '0;
         rx_sh_ff <= '0;
         rx_par_ff <= 1'b0;
      end else if (rx_tk) begin
         rx_os_ff <= rx_os_ff + 4'h1;
         unique case (rx_st_ff)
            line_pkg::st_idle: begin
               rx_os_ff <= '0;
               rx_bit_ff <= '0;
               rx_sh_ff <= '0;
               // The loopback tick that sees the start bit is its sample.
               if (!rx_line && loopback_select_ff)
                  rx_st_ff <= line_pkg::st_data;
               else if (!rx_line)
                  rx_st_ff <= line_pkg::st_start;
            end
            line_pkg::st_start: begin
               if (rx_mid && rx_line) rx_st_ff <= line_pkg::st_idle;
               if (rx_end) begin
                  rx_st_ff <= line_pkg::st_data;
                  rx_bit_ff <= '0;
                  rx_sh_ff <= '0;
               end
            end
            line_pkg::st_data: begin
               // Lsb first; shorter words land right-justified.
               if (rx_mid) rx_sh_ff[rx_bit_ff] <= rx_line;
               if (rx_end) begin
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == last_bit)
                     rx_st_ff <= par_en ? line_pkg::st_parity
                                        : line_pkg::st_stop;
               end
            end
            line_pkg::st_parity: begin
               if (rx_mid) rx_par_ff <= rx_line;
               if (rx_end) rx_st_ff <= line_pkg::st_stop;
            end
            line_pkg::st_stop: begin
               if (rx_mid) rx_st_ff <= line_pkg::st_idle;
            end
            default: rx_st_ff <= line_pkg::st_idle;
         endcase
      end
   end

   // Received parity check against the strap sense.
   wire par_bad = par_en && ((^rx_sh_ff ^ rx_par_ff) != !even);

   // Holding register and status flags; setting wins over reading.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_hold_ff <= '0;
         rx_char_complete_ff <= 1'b0;
         over_ff <= 1'b0;
         rx_stop_bit_flag_ff <= 1'b0;
         par_ff <= 1'b0;
      end else if (stop_mid) begin
         rx_hold_ff <= rx_sh_ff;
         rx_char_complete_ff <= 1'b1;
         over_ff <= rx_char_complete_ff && !(rd_now && haddr[3:0] ==
                    line_pkg::rx_buf_off);
         rx_stop_bit_flag_ff <= !rx_line;
         par_ff <= par_bad;
      end else if (rd_now && haddr[3:0] == line_pkg::rx_buf_off) begin
         rx_char_complete_ff <= 1'b0;
      end
   end

   // Transmit machine; breaks the holding register into the shifter.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_ff <= line_pkg::st_idle;
         tx_sh_ff <= '0;
         tx_bit_ff <= '0;
         tx_half_ff <= '0;
         tx_par_ff <= 1'b0;
         line_ff <= 1'b1;
      end else if (tx_tk) begin
         unique case (tx_st_ff)
            line_pkg::st_idle: begin
               line_ff <= 1'b1;
               if (hold_full_ff) begin
                  tx_sh_ff <= tx_hold_ff;
                  tx_par_ff <= ^tx_hold_ff ^ !even;
                  tx_st_ff <= line_pkg::st_start;
                  line_ff <= 1'b0;
               end
            end
            line_pkg::st_start: begin
               line_ff <= tx_sh_ff[0];
               tx_bit_ff <= '0;
               tx_st_ff <= line_pkg::st_data;
            end
            line_pkg::st_data: begin
               tx_bit_ff <= tx_bit_ff + 3'h1;
               line_ff <= tx_sh_ff[tx_bit_ff + 3'h1];
               if (tx_bit_ff == last_bit) begin
                  tx_st_ff <= par_en ? line_pkg::st_parity
                                     : line_pkg::st_stop;
                  line_ff <= par_en ? tx_par_ff : 1'b1;
                  tx_half_ff <= '0;
               end
            end
            line_pkg::st_parity: begin
               tx_st_ff <= line_pkg::st_stop;
               line_ff <= 1'b1;
            end
            line_pkg::st_stop: begin
               // Stop length counted in whole ticks; 1.5 rounds to 2.
               tx_half_ff <= tx_half_ff + 2'h1;
               if (straps.stop_sel == 2'h0 || tx_half_ff == 2'h1)
                  tx_st_ff <= line_pkg::st_idle;
            end
            default: tx_st_ff <= line_pkg::st_idle;
         endcase
      end
   end

   wire tx_load = tx_tk && tx_st_ff == line_pkg::st_idle && hold_full_ff;
   wire tx_wr   = wr_now && addr_ff == line_pkg::tx_buf_off;

   // Holding register; the shifter load takes it, a write refills it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_hold_ff <= '0;
         hold_full_ff <= 1'b0;
         tx_buffer_empty_ff <= 1'b1;
      end else if (tx_wr) begin
         tx_hold_ff <= hwdata[7:0];
         hold_full_ff <= 1'b1;
         tx_buffer_empty_ff <= 1'b0;
      end else if (tx_load) begin
         hold_full_ff <= 1'b0;
         tx_buffer_empty_ff <= 1'b1;
      end
   end

   // Rising modem input edges set the sticky data-set flag; read of status clears.
   wire ds_edge = |(modem_in & ~mdm_ff);
   wire rs_rd   = rd_now && haddr[3:0] == line_pkg::rx_status_off;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mdm_ff <= '0;
         ds_int_ff <= 1'b0;
      end else if (clk_en) begin
         mdm_ff <= modem_in;
         if (ds_edge) ds_int_ff <= 1'b1;
         else if (rs_rd) ds_int_ff <= 1'b0;
      end
   end

   // Control register writes.
   wire [15:0] wd = hwdata[15:0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {dtr_ff, rts_ff, rev_ff, ds_ie_ff, rx_ie_ff} <= '0;
         {tx_ie_ff, brk_ff, loopback_select_ff} <= '0;
      end else if (wr_now && addr_ff == line_pkg::rx_status_off) begin
         dtr_ff <= wd[line_pkg::rs_dtr];
         rts_ff <= wd[line_pkg::rs_rts];
         rev_ff <= wd[line_pkg::rs_rev_out];
         ds_ie_ff <= wd[line_pkg::rs_ds_ie];
         rx_ie_ff <= wd[line_pkg::rs_rx_ie];
      end else if (wr_now && addr_ff == line_pkg::tx_status_off) begin
         brk_ff <= wd[line_pkg::ts_break];
         loopback_select_ff <= wd[line_pkg::ts_loop];
         tx_ie_ff <= wd[line_pkg::ts_tx_ie];
      end
   end

   // Read multiplexer; modem status lives in receiver status.
   logic [15:0] rs_v, rb_v, ts_v, rd_v;
   always_comb begin
      rs_v = '0;
      rs_v[line_pkg::rs_dtr] = dtr_ff;
      rs_v[line_pkg::rs_rts] = rts_ff;
      rs_v[line_pkg::rs_rev_out] = rev_ff;
      rs_v[line_pkg::rs_ds_ie] = ds_ie_ff;
      rs_v[line_pkg::rs_rx_ie] = rx_ie_ff;
      rs_v[line_pkg::rs_done] = rx_char_complete_ff;
      rs_v[line_pkg::rs_rev_in] = modem_in.reverse_channel_in;
      rs_v[line_pkg::rs_active] = rx_st_ff != line_pkg::st_idle;
      rs_v[line_pkg::rs_tone] = modem_in.line_tone_present;
      rs_v[line_pkg::rs_cts] = modem_in.cts;
      rs_v[line_pkg::rs_ring] = modem_in.ring;
      rs_v[line_pkg::rs_ds_int] = ds_int_ff;
      rb_v = {8'h00, rx_hold_ff};
      rb_v[line_pkg::rb_par] = par_ff;
      rb_v[line_pkg::rb_frame] = rx_stop_bit_flag_ff;
      rb_v[line_pkg::rb_over] = over_ff;
      rb_v[line_pkg::rb_err] = par_ff | rx_stop_bit_flag_ff | over_ff;
      ts_v = '0;
      ts_v[line_pkg::ts_break] = brk_ff;
      ts_v[line_pkg::ts_loop] = loopback_select_ff;
      ts_v[line_pkg::ts_tx_ie] = tx_ie_ff;
      ts_v[line_pkg::ts_ready] = tx_buffer_empty_ff;
      unique case (haddr[3:0])
         line_pkg::rx_status_off: rd_v = rs_v;
         line_pkg::rx_buf_off:    rd_v = rb_v;
         line_pkg::tx_status_off: rd_v = ts_v;
         line_pkg::tx_buf_off:    rd_v = '0;
         default:                 rd_v = '0;
      endcase
   end

   // Bus slave: zero wait states, read data registered into data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         addr_ff <= '0;
         hrdata <= '0;
      end else if (clk_en) begin
         wr_pend_ff <= addr_ok && hwrite;
         addr_ff <= haddr[3:0];
         hrdata <= rd_now ? {16'h0000, rd_v} : '0;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = line_pkg::hresp_okay;

   // Output pins and interrupt requests, all from flip-flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_out <= 1'b1;
         rts_out <= 1'b0;
         dtr_out <= 1'b0;
         reverse_channel_out <= 1'b0;
         rx_irq <= 1'b0;
         tx_irq <= 1'b0;
      end else if (clk_en) begin
         // In loopback the line idles at mark toward the modem.
         serial_out <= brk_ff ? 1'b0 :
                       (loopback_select_ff ? 1'b1 : line_ff);
         rts_out <= rts_ff;
         dtr_out <= dtr_ff;
         reverse_channel_out <= rev_ff;
         rx_irq <= (rx_ie_ff && rx_char_complete_ff) ||
                   (ds_ie_ff && ds_int_ff);
         tx_irq <= tx_ie_ff && tx_buffer_empty_ff && !hold_full_ff
                   && tx_st_ff == line_pkg::st_idle;
      end
   end

   // Checks.
   a_done_on_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_mid |=> rx_char_complete_ff)
      else $error("done flag not set at stop centre");
   a_hold_loads: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_mid |=> rx_hold_ff == $past(rx_sh_ff))
      else $error("holding register not loaded");
   a_overrun_set: assert property (@(posedge hclk) disable iff (!hresetn)
      stop_mid && rx_char_complete_ff && !rd_now |=> over_ff)
      else $error("overrun missed");
   a_break_space: assert property (@(posedge hclk) disable iff (!hresetn)
      brk_ff && clk_en |=> !serial_out)
      else $error("break not space");
   a_ds_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && !ds_ie_ff && !rx_char_complete_ff |=> !rx_irq)
      else $error("data-set interrupt while disabled");
   a_ds_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && ds_edge |=> ds_int_ff)
      else $error("modem edge lost");
   a_tx_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_wr |=> !tx_buffer_empty_ff && hold_full_ff)
      else $error("write did not fill holding register");
   a_rts_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en |=> rts_out == $past(rts_ff))
      else $error("rts does not follow control bit");
   c_rx_char: cover property (@(posedge hclk) stop_mid);
   c_tx_load: cover property (@(posedge hclk) tx_load);
   c_ds_irq: cover property (@(posedge hclk) ds_int_ff && ds_ie_ff);
endmodule
`default_nettype wire

// ==== rtl/line_pkg.sv ====
package line_pkg;
   // Register byte offsets on the bus.
   localparam logic [3:0] rx_status_off = 4'h0;
   localparam logic [3:0] rx_buf_off    = 4'h4;
   localparam logic [3:0] tx_status_off = 4'h8;
   localparam logic [3:0] tx_buf_off    = 4'hc;
   // Receiver status bit positions.
   localparam int rs_dtr    = 1;
   localparam int rs_rts    = 2;
   localparam int rs_rev_out = 3;
   localparam int rs_ds_ie  = 5;
   localparam int rs_done   = 7;
   localparam int rs_rx_ie  = 6;
   localparam int rs_rev_in = 10;
   localparam int rs_active = 11;
   localparam int rs_tone   = 12;
   localparam int rs_cts    = 13;
   localparam int rs_ring   = 14;
   localparam int rs_ds_int = 15;
   // Receive buffer status bit positions.
   localparam int rb_par    = 12;
   localparam int rb_frame  = 13;
   localparam int rb_over   = 14;
   localparam int rb_err    = 15;
   // Transmitter status bit positions.
   localparam int ts_break  = 0;
   localparam int ts_loop   = 2;
   localparam int ts_tx_ie  = 6;
   localparam int ts_ready  = 7;
   // Index of the last and of the middle sample in a receive bit.
   localparam logic [3:0] os_last = 4'hf;
   localparam logic [3:0] os_mid  = 4'h7;
   localparam logic [1:0] hresp_okay = 2'h0;
   localparam logic [1:0] htrans_nonseq = 2'h2;

   // Format straps; a fitted strap reads low.
   typedef struct packed {
      logic [1:0] len_sel;       // 00=5 ... 11=8 data bits.
      logic       parity_off_strap;
      logic       even_parity_strap;
      logic [1:0] stop_sel;      // 00=1, 01=1.5, other=2 stop bits.
   } straps_t;

   // Modem status inputs.
   typedef struct packed {
      logic ring;
      logic cts;
      logic line_tone_present;
      logic reverse_channel_in;
   } modem_in_t;

   typedef enum logic [2:0] {
      st_idle   = 3'b000,
      st_start  = 3'b001,
      st_data   = 3'b011,
      st_parity = 3'b010,
      st_stop   = 3'b110
   } ser_st_t;
endpackage

// ==== bench/modem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module modem_model (
   input  wire logic           hclk,
   input  wire logic           serial_out,
   input  wire logic           dtr_out,
   input  wire logic           rts_out,
   output logic                serial_in,
   output line_pkg::modem_in_t modem_in
);
   logic       ring_r;
   logic       cts_r;
   logic       tone_r;
   logic       rev_r;
   logic [5:0] ans_cnt;

   // Status leads as one bundle; the line rests at mark between frames.
   assign modem_in = {ring_r, cts_r, tone_r, rev_r};
   initial begin
      {ring_r, cts_r, tone_r, rev_r} = 4'h0;
      ans_cnt = 6'h00;
      serial_in = 1'b1;
   end

   // A ringing set answers with tone some time after both leads come up.
   always @(posedge hclk) begin
      if (ring_r && dtr_out && rts_out && !tone_r) begin
         ans_cnt <= ans_cnt + 6'h01;
         if (ans_cnt == 6'h14) tone_r <= 1'b1;
      end
   end

   task automatic set_lines(input logic r, input logic c, input logic v);
      @(posedge hclk);
      ring_r <= r;
      cts_r <= c;
      rev_r <= v;
   endtask

   // Start, data low bit first, optional parity, stop in half bits.
   task automatic send_char(input logic [7:0] d, input int nb,
                            input logic pen, input logic pb,
                            input int halves, input logic sv);
      @(posedge hclk);
      serial_in <= 1'b0;
      repeat (32) @(posedge hclk);
      for (int i = 0; i < nb; i++) begin
         serial_in <= d[i];
         repeat (32) @(posedge hclk);
      end
      if (pen) begin
         serial_in <= pb;
         repeat (32) @(posedge hclk);
      end
      serial_in <= sv;
      repeat (16 * halves) @(posedge hclk);
      serial_in <= 1'b1;
      repeat (32) @(posedge hclk);
   endtask

   // Samples each bit at its centre, a bit lasting 32 clocks.
   task automatic recv_char(input int nb, input logic pen,
                            output logic [7:0] d, output logic pb,
                            output logic sb);
      d = 8'h00;
      pb = 1'b0;
      while (serial_out !== 1'b0) @(posedge hclk);
      repeat (16) @(posedge hclk);
      for (int i = 0; i < nb; i++) begin
         repeat (32) @(posedge hclk);
         d[i] = serial_out;
      end
      if (pen) begin
         repeat (32) @(posedge hclk);
         pb = serial_out;
      end
      repeat (32) @(posedge hclk);
      sb = serial_out;
   endtask
endmodule
`default_nettype wire

// ==== bench/async_line_with_modem_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module async_line_with_modem_control_tb;
   logic                hclk;
   logic                hresetn;
   logic                hsel;
   logic                hwrite;
   logic [31:0]         haddr;
   logic [31:0]         hwdata;
   logic [31:0]         hrdata;
   logic [31:0]         rd;
   logic [31:0]         e;
   logic [1:0]          htrans;
   logic [1:0]          hresp;
   logic [2:0]          hsize;
   logic                hreadyout;
   line_pkg::straps_t   straps;
   line_pkg::modem_in_t modem_in;
   logic                rx_tick16;
   logic                tx_tick;
   logic [4:0]          tick_cnt;
   logic                serial_in;
   logic                serial_out;
   logic                rts_out;
   logic                dtr_out;
   logic                reverse_channel_out;
   logic                rx_irq;
   logic                tx_irq;
   logic [7:0]          v1;
   logic [7:0]          v2;
   logic                p1;
   logic                p2;
   logic                s1;
   logic                s2;
   int                  mismatches;
   int                  comparisons;
   logic [5:0]          fmt [4] = '{6'h38, 6'h01, 6'h26, 6'h10};
   logic [7:0]          dat [4] = '{8'ha5, 8'h13, 8'h5a, 8'h2c};

   async_line_with_modem_control dut_u (
      .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .straps(straps),
      .rx_tick16(rx_tick16), .tx_tick(tx_tick), .serial_in(serial_in),
      .modem_in(modem_in), .serial_out(serial_out), .rts_out(rts_out),
      .dtr_out(dtr_out), .reverse_channel_out(reverse_channel_out),
      .rx_irq(rx_irq), .tx_irq(tx_irq));

   modem_model mdm_u (
      .hclk(hclk), .serial_out(serial_out), .dtr_out(dtr_out),
      .rts_out(rts_out), .serial_in(serial_in), .modem_in(modem_in));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Sixteen receive ticks and one transmit tick per 32-clock bit.
   always @(posedge hclk) begin
      tick_cnt <= tick_cnt + 5'h01;
      rx_tick16 <= tick_cnt[0];
      tx_tick <= (tick_cnt == 5'h1f);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single word transfer; the wait is cut only by the timeout.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= line_pkg::htrans_nonseq;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, x);
      chk({30'h0, hresp}, {30'h0, line_pkg::hresp_okay});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // Sets the straps, then sends one frame in that format.
   task automatic send_fmt(input logic [5:0] f, input logic [7:0] d,
                           input logic bp, input logic sv,
                           output logic [31:0] x);
      int         nb;
      logic [7:0] m;
      nb = int'(f[5:4]) + 5;
      m = d & ~(8'hff << nb);
      x = {24'h0, m};
      @(posedge hclk);
      straps <= f;
      mdm_u.send_char(m, nb, !f[3], (^m) ^ f[2] ^ bp,
                      (f[1:0] == 2'h0) ? 2 : ((f[1:0] == 2'h1) ? 3 : 4), sv);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hang counts as a mismatch and still ends in the report.
   initial begin
      repeat (60000) @(posedge hclk);
      mismatches++;
      finish_test;
   end

   initial begin
      {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      {rx_tick16, tx_tick, tick_cnt, mismatches, comparisons} = '0;
      straps = 6'h38;
      hresetn = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(8'h8, 32'h80);
      rdc(8'h0, 32'h0);
      wr(8'h10, 32'hffff);
      rdc(8'h10, 32'h0);
      // Modem events, first with the enable off, then a full answer.
      mdm_u.set_lines(1'b0, 1'b1, 1'b0);
      cyc(8);
      chk({31'h0, rx_irq}, 32'h0);
      rdc(8'h0, 32'ha000);
      rdc(8'h0, 32'h2000);
      wr(8'h0, 32'h20);
      mdm_u.set_lines(1'b1, 1'b1, 1'b0);
      cyc(8);
      chk({31'h0, rx_irq}, 32'h1);
      rdc(8'h0, 32'he020);
      wr(8'h0, 32'h26);
      cyc(2);
      chk({30'h0, rts_out, dtr_out}, 32'h3);
      for (int i = 0; i < 100 && rx_irq !== 1'b1; i++) cyc(1);
      chk({31'h0, rx_irq}, 32'h1);
      rdc(8'h0, 32'hf026);
      cyc(2);
      chk({31'h0, rx_irq}, 32'h0);
      wr(8'h0, 32'h2e);
      mdm_u.set_lines(1'b1, 1'b1, 1'b1);
      cyc(8);
      chk({31'h0, reverse_channel_out}, 32'h1);
      rdc(8'h0, 32'hf42e);
      wr(8'h0, 32'h44);
      cyc(2);
      chk({29'h0, rts_out, dtr_out, reverse_channel_out}, 32'h4);
      // Every length once; each parity sense and stop count at least once.
      for (int k = 0; k < 4; k++) begin
         fork
            send_fmt(fmt[k], dat[k], 1'b0, 1'b1, e);
            begin
               cyc(200);
               rdc(8'h0, 32'h7c44);
            end
         join
         chk({31'h0, rx_irq}, 32'h1);
         rdc(8'h0, 32'h74c4);
         rdc(8'h4, e);
         rdc(8'h0, 32'h7444);
      end
      // Bad parity, bad stop, then a character left unread.
      send_fmt(6'h30, 8'h6b, 1'b1, 1'b1, e);
      rdc(8'h4, e | 32'h9000);
      send_fmt(6'h30, 8'h6b, 1'b0, 1'b0, e);
      rdc(8'h4, e | 32'ha000);
      send_fmt(6'h30, 8'h11, 1'b0, 1'b1, e);
      send_fmt(6'h30, 8'h22, 1'b0, 1'b1, e);
      rdc(8'h4, e | 32'hc000);
      // Two characters back to back; the second waits in the holding stage.
      wr(8'h8, 32'h40);
      fork
         begin
            mdm_u.recv_char(8, 1'b1, v1, p1, s1);
            mdm_u.recv_char(8, 1'b1, v2, p2, s2);
         end
         begin
            wr(8'hc, 32'h3c);
            // Refill the holding stage only once it reports ready.
            rd = 32'h0;
            for (int i = 0; i < 100 && rd[7] !== 1'b1; i++)
               bus(1'b0, 8'h8, 32'h0, rd);
            wr(8'hc, 32'hc1);
            rdc(8'h8, 32'h40);
         end
      join
      chk({v1, p1, s1, v2, p2, s2}, 32'h0003c707);
      for (int i = 0; i < 100 && tx_irq !== 1'b1; i++) cyc(1);
      chk({31'h0, tx_irq}, 32'h1);
      rdc(8'h8, 32'hc0);
      wr(8'h8, 32'h01);
      for (int i = 0; i < 4; i++) begin
         cyc(20);
         chk({31'h0, serial_out}, 32'h0);
      end
      wr(8'h8, 32'h00);
      cyc(40);
      chk({31'h0, serial_out}, 32'h1);
      // Loopback keeps the line at mark and feeds the receiver.
      wr(8'h8, 32'h04);
      wr(8'hc, 32'h96);
      cyc(100);
      chk({31'h0, serial_out}, 32'h1);
      rd = 32'h0;
      for (int i = 0; i < 300 && rd[7] !== 1'b1; i++)
         bus(1'b0, 8'h0, 32'h0, rd);
      rdc(8'h4, 32'h96);
      finish_test;
   end
endmodule
`default_nettype wire
